/* File: src/nae_pkg.sv */
// Constants, opcodes and types for the nibble ALU execute block.
// Assumes a 16-bit instruction word presented once per machine cycle.
package nae_pkg;
  // Widths
  localparam int DATA_W  = 4;
  localparam int ADDR_W  = 7;
  localparam int PC_W    = 11;
  localparam int INSTR_W = 16;
  localparam int WSEL_W  = 4;
  // Field positions
  localparam int OP9_LSB  = 7;
  localparam int OP8_LSB  = 8;
  localparam int OP5_LSB  = 11;
  localparam int MEM_LSB  = 0;
  localparam int IMM_LSB  = 4;
  localparam int WSEL_LSB = 0;
  localparam int CALL_LSB = 0;
  // Opcodes, memory forms (9-bit)
  localparam logic [8:0] OPC_ADD_MEM    = 9'h050;
  localparam logic [8:0] OPC_ADD_MEM_WB = 9'h052;
  localparam logic [8:0] OPC_AND_MEM    = 9'h054;
  localparam logic [8:0] OPC_AND_MEM_WB = 9'h056;
  // Opcodes, immediate forms (8-bit)
  localparam logic [7:0] OPC_ADD_IMM    = 8'h2C;
  localparam logic [7:0] OPC_ADD_IMM_WB = 8'h2D;
  localparam logic [7:0] OPC_AND_IMM    = 8'h2E;
  localparam logic [7:0] OPC_AND_IMM_WB = 8'h2F;
  // Call and clear carry
  localparam logic [4:0]  OPC_CALL      = 5'h0C;
  localparam logic [15:0] OPC_CLR_CARRY = 16'h5000;
  // Working registers sit at the bottom of data memory
  localparam logic [2:0]  WR_BASE_HI    = 3'h0;
  // Reset values and program counter step
  localparam logic [3:0]  ACC_RST   = 4'h0;
  localparam logic [10:0] PC_RST    = 11'h000;
  localparam logic        CARRY_RST = 1'b0;
  localparam logic        ZERO_RST  = 1'b0;
  localparam logic [10:0] PC_ONE    = 11'h001;

  typedef enum {
    NAE_OP_NONE,
    NAE_OP_ADD_MEM,
    NAE_OP_ADD_MEM_WB,
    NAE_OP_AND_MEM,
    NAE_OP_AND_MEM_WB,
    NAE_OP_ADD_IMM,
    NAE_OP_ADD_IMM_WB,
    NAE_OP_AND_IMM,
    NAE_OP_AND_IMM_WB,
    NAE_OP_CALL,
    NAE_OP_CLR_CARRY
  } nae_op_t;

  // 4-bit add with carry discarded
  function automatic logic [3:0] nae_add4(input logic [3:0] a,
                                          input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[3:0];
  endfunction

  // Zero test on a result nibble
  function automatic logic nae_is_zero(input logic [3:0] v);
    return (v == 4'h0);
  endfunction
endpackage

/* File: src/nae_dec_if.sv */
// Decoded instruction fields passed from decoder to execute logic.
// Assumes one decoder drives it and one execute stage reads it.
`timescale 1ns/10ps
interface nae_dec_if;
  import nae_pkg::*;
  nae_op_t     op;
  logic [6:0]  mem_addr;
  logic [3:0]  wr_sel;
  logic [3:0]  imm;
  logic [10:0] call_addr;

  modport dec (output op, mem_addr, wr_sel, imm, call_addr);
  modport exe (input  op, mem_addr, wr_sel, imm, call_addr);
endinterface

/* File: src/nae_decode.sv */
// Combinational opcode decoder for the nibble ALU execute block.
// Assumes the instruction word is stable for the whole machine cycle.
`timescale 1ns/10ps
module nae_decode
  import nae_pkg::*;
(
  // Instruction
  input  wire logic [15:0] i_instr,
  // Decoded fields
  nae_dec_if.dec           dec
);
  logic [8:0] op9;
  logic [7:0] op8;
  logic [4:0] op5;

  assign op9 = i_instr[OP9_LSB +: 9];
  assign op8 = i_instr[OP8_LSB +: 8];
  assign op5 = i_instr[OP5_LSB +: 5];

  assign dec.mem_addr  = i_instr[MEM_LSB +: ADDR_W];  // RULE9
  assign dec.wr_sel    = i_instr[WSEL_LSB +: WSEL_W]; // RULE13
  assign dec.imm       = i_instr[IMM_LSB +: DATA_W];
  assign dec.call_addr = i_instr[CALL_LSB +: PC_W];   // RULE10

  always_comb begin
    dec.op = NAE_OP_NONE;
    if (i_instr == OPC_CLR_CARRY) begin
      dec.op = NAE_OP_CLR_CARRY;
    end else if (op5 == OPC_CALL) begin
      dec.op = NAE_OP_CALL;
    end else if (op9 == OPC_ADD_MEM) begin
      dec.op = NAE_OP_ADD_MEM;
    end else if (op9 == OPC_ADD_MEM_WB) begin
      dec.op = NAE_OP_ADD_MEM_WB;
    end else if (op9 == OPC_AND_MEM) begin
      dec.op = NAE_OP_AND_MEM;
    end else if (op9 == OPC_AND_MEM_WB) begin
      dec.op = NAE_OP_AND_MEM_WB;
    end else if (op8 == OPC_ADD_IMM) begin
      dec.op = NAE_OP_ADD_IMM;
    end else if (op8 == OPC_ADD_IMM_WB) begin
      dec.op = NAE_OP_ADD_IMM_WB;
    end else if (op8 == OPC_AND_IMM) begin
      dec.op = NAE_OP_AND_IMM;
    end else if (op8 == OPC_AND_IMM_WB) begin
      dec.op = NAE_OP_AND_IMM_WB;
    end
  end
endmodule

/* File: src/nae_core.sv */
// Execute stage for carry-keeping adds, ANDs, subroutine call and carry
// clear of a 4-bit core; holds data memory, flags, PC and return stack.
// Assumes instructions come from logic on i_mclk, one per machine cycle.
//
// Function
// RULE1 - Add-immediate: accumulator gets working register plus immediate.
// RULE2 - Add-memory writeback: sum goes to accumulator and same memory word.
// RULE3 - Add-immediate writeback: sum to working register and accumulator.
// RULE4 - Carry-keeping adds leave carry alone, update zero flag only.
// RULE5 - AND-memory: accumulator gets memory AND accumulator, zero flag only.
// RULE6 - AND-immediate: accumulator gets working register AND immediate.
// RULE7 - AND-memory writeback: result to memory word and accumulator.
// RULE8 - AND-immediate writeback: result to working register and accumulator.
// RULE9 - Memory operand address is the 7-bit field in low instruction bits.
// RULE10 - Call pushes program counter plus one, then loads 11-bit address.
// RULE11 - Clear-carry zeroes carry flag and touches nothing else.
// RULE12 - Zero flag set when result is zero; one machine cycle each.
// RULE13 - Working register chosen by 4-bit low field, one of sixteen.
`timescale 1ns/10ps
module nae_core
  import nae_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int MEM_WORDS   = 128
)(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Instruction
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  // Memory preload
  input  wire logic        i_mem_load,
  input  wire logic [6:0]  i_mem_load_addr,
  input  wire logic [3:0]  i_mem_load_data,
  // Carry preload
  input  wire logic        i_carry_load,
  input  wire logic        i_carry_value,
  // Memory observation
  input  wire logic [6:0]  i_peek_addr,
  // Core state
  output logic [3:0]       o_accumulator_nibble,
  output logic             o_carry_flag,
  output logic             o_zero_flag,
  output logic [10:0]      o_program_counter,
  output logic [10:0]      o_stack_top,
  output logic [3:0]       o_stack_level,
  output logic [3:0]       o_peek_data,
  // Status pulses
  output logic             o_done,
  output logic             o_unknown_op
);
  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [SP_W-1:0] SP_RST   = '0;
  localparam logic [SP_W-1:0] SP_ONE   = {{(SP_W-1){1'b0}}, 1'b1};
  localparam logic [SP_W-1:0] SP_LAST  = SP_W'(STACK_DEPTH - 1);
  localparam logic [3:0]      LVL_MAX  = 4'(STACK_DEPTH);
  localparam logic [3:0]      LVL_RST  = 4'h0;

  // Bitwise AND shared by the memory and immediate forms
  function automatic logic [3:0] nae_and4(input logic [3:0] a,
                                          input logic [3:0] b);
    return a & b;
  endfunction

  nae_dec_if dec_if ();

  nae_decode u_decode (
    .i_instr (i_instr),
    .dec     (dec_if.dec)
  );

  // Storage
  logic [3:0]      mem_r [MEM_WORDS];
  logic [10:0]     stack_r [STACK_DEPTH];
  logic [3:0]      acc_r;
  logic            carry_r;
  logic            zero_r;
  logic [10:0]     pc_r;
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_next;
  logic [SP_W-1:0] sp_prev;
  logic [3:0]      level_r;
  logic [10:0]     top_r;
  logic [3:0]      peek_r;
  logic            done_r;
  logic            unknown_r;

  // Operands and results
  logic [6:0]  wr_addr;
  logic [3:0]  mem_opnd;
  logic [3:0]  wr_opnd;
  logic [3:0]  result_nxt;
  logic        acc_we;
  logic        mem_we;
  logic [6:0]  mem_we_addr;
  logic        clr_carry;
  logic        do_call;
  logic        is_legal;
  logic [10:0] pc_inc;
  logic [10:0] pc_nxt;

  assign wr_addr  = {WR_BASE_HI, dec_if.wr_sel};          // RULE13
  assign mem_opnd = mem_r[dec_if.mem_addr];               // RULE9
  assign wr_opnd  = mem_r[wr_addr];
  assign pc_inc   = pc_r + PC_ONE;
  assign sp_next  = (sp_r == SP_LAST) ? SP_RST : sp_r + SP_ONE;
  assign sp_prev  = (sp_r == SP_RST) ? SP_LAST : sp_r - SP_ONE;

  // Operation select
  always_comb begin
    result_nxt  = 4'h0;
    acc_we      = 1'b0;
    mem_we      = 1'b0;
    mem_we_addr = dec_if.mem_addr;
    clr_carry   = 1'b0;
    do_call     = 1'b0;
    is_legal    = 1'b1;
    case (dec_if.op)
      NAE_OP_ADD_MEM: begin
        result_nxt = nae_add4(mem_opnd, acc_r);
        acc_we     = 1'b1;
      end
      NAE_OP_ADD_MEM_WB: begin
        result_nxt = nae_add4(mem_opnd, acc_r);           // RULE2
        acc_we     = 1'b1;
        mem_we     = 1'b1;
      end
      NAE_OP_AND_MEM: begin
        result_nxt = nae_and4(mem_opnd, acc_r);           // RULE5
        acc_we     = 1'b1;
      end
      NAE_OP_AND_MEM_WB: begin
        result_nxt = nae_and4(mem_opnd, acc_r);           // RULE7
        acc_we     = 1'b1;
        mem_we     = 1'b1;
      end
      NAE_OP_ADD_IMM: begin
        result_nxt = nae_add4(wr_opnd, dec_if.imm);       // RULE1
        acc_we     = 1'b1;
      end
      NAE_OP_ADD_IMM_WB: begin
        result_nxt  = nae_add4(wr_opnd, dec_if.imm);      // RULE3
        acc_we      = 1'b1;
        mem_we      = 1'b1;
        mem_we_addr = wr_addr;
      end
      NAE_OP_AND_IMM: begin
        result_nxt = nae_and4(wr_opnd, dec_if.imm);       // RULE6
        acc_we     = 1'b1;
      end
      NAE_OP_AND_IMM_WB: begin
        result_nxt  = nae_and4(wr_opnd, dec_if.imm);      // RULE8
        acc_we      = 1'b1;
        mem_we      = 1'b1;
        mem_we_addr = wr_addr;
      end
      NAE_OP_CALL: begin
        do_call = 1'b1;
      end
      NAE_OP_CLR_CARRY: begin
        clr_carry = 1'b1;
      end
      default: begin
        is_legal = 1'b0;
      end
    endcase
  end

  // Accumulator
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_r <= ACC_RST;
    end else if (i_instr_valid && acc_we) begin
      acc_r <= result_nxt;                                // RULE12
    end
  end

  // Zero flag, written only by ALU results
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      zero_r <= ZERO_RST;
    end else if (i_instr_valid && acc_we) begin
      zero_r <= nae_is_zero(result_nxt);                  // RULE12 RULE4
    end
  end

  // Carry flag, untouched by the adds; clear beats preload
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      carry_r <= CARRY_RST;
    end else if (i_instr_valid && clr_carry) begin
      carry_r <= 1'b0;                                    // RULE11
    end else if (i_carry_load) begin
      carry_r <= i_carry_value;                           // RULE4
    end
  end

  // Data memory, instruction write beats preload
  always_ff @(posedge i_mclk) begin
    if (i_instr_valid && mem_we) begin
      mem_r[mem_we_addr] <= result_nxt;                   // RULE2 RULE7
    end else if (i_mem_load) begin
      mem_r[i_mem_load_addr] <= i_mem_load_data;
    end
  end

  // Next program counter
  always_comb begin
    pc_nxt = pc_inc;
    if (do_call) begin
      pc_nxt = dec_if.call_addr;                          // RULE10
    end
  end

  // Program counter, steps on every valid word except a call, which loads its target
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pc_r <= PC_RST;
    end else if (i_instr_valid) begin
      pc_r <= pc_nxt;
    end
  end

  // Return stack, circular; oldest entry is lost on overflow
  always_ff @(posedge i_mclk) begin
    if (i_instr_valid && do_call) begin
      stack_r[sp_r] <= pc_inc;                            // RULE10
    end
  end

  // Stack pointer, wraps
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sp_r <= SP_RST;
    end else if (i_instr_valid && do_call) begin
      sp_r <= sp_next;
    end
  end

  // Stack level, saturates at the depth
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      level_r <= LVL_RST;
    end else if (i_instr_valid && do_call) begin
      level_r <= (level_r == LVL_MAX) ? LVL_MAX : level_r + 4'h1;
    end
  end

  // Stack top, read back from the stack once anything was pushed
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      top_r <= PC_RST;
    end else if (i_instr_valid && do_call) begin
      top_r <= pc_inc;                                    // RULE10
    end else if (level_r != LVL_RST) begin
      top_r <= stack_r[sp_prev];
    end
  end

  // Completion pulse, one cycle per accepted word
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= i_instr_valid && is_legal;                // RULE12
    end
  end

  // Refusal pulse for words outside this group
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      unknown_r <= 1'b0;
    end else begin
      unknown_r <= i_instr_valid && !is_legal;
    end
  end

  // Memory observation, one cycle late
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      peek_r <= 4'h0;
    end else begin
      peek_r <= mem_r[i_peek_addr];
    end
  end

  assign o_accumulator_nibble = acc_r;
  assign o_carry_flag         = carry_r;
  assign o_zero_flag          = zero_r;
  assign o_program_counter    = pc_r;
  assign o_stack_top          = top_r;
  assign o_stack_level        = level_r;
  assign o_peek_data          = peek_r;
  assign o_done               = done_r;
  assign o_unknown_op         = unknown_r;
endmodule

/* File: bench/nae_core_properties.sv */
// Concurrent checks on the ports of the nibble ALU execute block.
// Assumes one clock i_mclk and asynchronous active-high reset i_rst.
`timescale 1ns/10ps
module nae_core_properties
  import nae_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic        i_carry_load,
  input wire logic [3:0]  o_accumulator_nibble,
  input wire logic        o_carry_flag,
  input wire logic        o_zero_flag,
  input wire logic [10:0] o_program_counter,
  input wire logic [10:0] o_stack_top,
  input wire logic        o_done,
  input wire logic        o_unknown_op
);
  logic clr;
  logic call;
  logic alu;
  assign clr  = i_instr_valid && (i_instr == OPC_CLR_CARRY);
  assign call = i_instr_valid && (i_instr[15:11] == OPC_CALL);
  assign alu  = i_instr_valid && (i_instr[15:12] == 4'h2);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_carry_kept: assert property (
    alu && !i_carry_load |=> $stable(o_carry_flag))
    else $error("carry moved on add or and");
  a_clr_zero: assert property (clr |=> !o_carry_flag)
    else $error("carry not cleared");
  a_clr_quiet: assert property (
    clr |=> $stable(o_accumulator_nibble) && $stable(o_zero_flag))
    else $error("clear carry touched other state");
  a_call_jump: assert property (
    call |=> o_program_counter == $past(i_instr[10:0]))
    else $error("call target not loaded");
  a_call_push: assert property (
    call |=> o_stack_top == $past(o_program_counter) + PC_ONE)
    else $error("call pushed wrong return address");
  a_zero_match: assert property (
    alu |=> o_unknown_op || (o_zero_flag == (o_accumulator_nibble == 4'h0)))
    else $error("zero flag disagrees with result");
  a_and_imm_mask: assert property (
    i_instr_valid && i_instr[15:9] == 7'h17
    |=> (o_accumulator_nibble & ~$past(i_instr[7:4])) == 4'h0)
    else $error("and immediate set bits outside mask");
  a_and_mem_mask: assert property (
    i_instr_valid && i_instr[15:9] == 7'h15 && !i_instr[7]
    |=> (o_accumulator_nibble & ~$past(o_accumulator_nibble)) == 4'h0)
    else $error("and memory set new bits");
  a_one_cycle: assert property (i_instr_valid |=> o_done != o_unknown_op)
    else $error("no single status pulse");
  a_pc_step: assert property (
    i_instr_valid && !call
    |=> o_program_counter == $past(o_program_counter) + PC_ONE)
    else $error("program counter did not step");
endmodule

bind nae_core nae_core_properties nae_core_properties_i (
  .i_mclk, .i_rst, .i_instr_valid, .i_instr, .i_carry_load,
  .o_accumulator_nibble, .o_carry_flag, .o_zero_flag,
  .o_program_counter, .o_stack_top, .o_done, .o_unknown_op
);

/* File: bench/nae_tb.sv */
// Self-checking bench for the nibble ALU execute block.
// Assumes the checker is bound in; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  import nae_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic        i_mem_load = 1'b0;
  logic [6:0]  i_mem_load_addr = 7'h00;
  logic [3:0]  i_mem_load_data = 4'h0;
  logic        i_carry_load = 1'b0;
  logic        i_carry_value = 1'b0;
  logic [6:0]  i_peek_addr = 7'h00;
  logic [3:0]  acc;
  logic        cf;
  logic        zf;
  logic [10:0] pc;
  logic [10:0] top;
  logic [3:0]  lvl;
  logic [3:0]  pk;
  logic        done;
  logic        unk;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [10:0] exp_pc = 11'h000;
  logic [10:0] tbl [8] = '{11'h059, 11'h0F4, 11'h7FA, 11'h40F,
                           11'h020, 11'h216, 11'h22B, 11'h03E};

  nae_core nae_core_i (
    .i_mclk, .i_rst, .i_instr_valid, .i_instr, .i_mem_load,
    .i_mem_load_addr, .i_mem_load_data, .i_carry_load, .i_carry_value,
    .i_peek_addr, .o_accumulator_nibble(acc), .o_carry_flag(cf),
    .o_zero_flag(zf), .o_program_counter(pc), .o_stack_top(top),
    .o_stack_level(lvl), .o_peek_data(pk), .o_done(done), .o_unknown_op(unk)
  );

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic st(input logic [3:0] a, input logic z, input logic c);
    chk(11'(acc), 11'(a));
    chk(11'(zf), 11'(z));
    chk(11'(cf), 11'(c));
  endtask

  task automatic peek(input logic [6:0] a, input logic [3:0] d);
    i_peek_addr = a;
    @(negedge i_mclk);
    chk(11'(pk), 11'(d));
  endtask

  // Holds valid high so calls may run back to back
  task automatic exec(input logic [15:0] w);
    i_instr_valid = 1'b1;
    i_instr = w;
    @(negedge i_mclk);
    exp_pc = (w[15:11] == OPC_CALL) ? w[10:0] : exp_pc + PC_ONE;
  endtask

  task automatic idle();
    i_instr_valid = 1'b0;
    i_carry_load = 1'b0;
    @(negedge i_mclk);
  endtask

  task automatic preload();
    i_mem_load = 1'b1;
    for (int k = 0; k < 8; k++) begin
      {i_mem_load_addr, i_mem_load_data} = tbl[k];
      @(negedge i_mclk);
    end
    i_mem_load = 1'b0;
    i_carry_load = 1'b1;
    i_carry_value = 1'b1;
    @(negedge i_mclk);
    i_carry_load = 1'b0;
  endtask

  task automatic t_adds();
    exec(16'h2C75);
    idle();
    st(4'h9 + 4'h7, 1'b1, 1'b1);
    peek(7'h05, 4'h9);
    exec(16'h2D3F);
    idle();
    st(4'h7, 1'b0, 1'b1);
    peek(7'h0F, 4'h7);
    exec(16'h297F);
    exec(16'h2840);
    idle();
    st(4'h7 + 4'hA + 4'hF, 1'b1, 1'b1);
    peek(7'h7F, 4'h7 + 4'hA);
    peek(7'h40, 4'hF);
  endtask

  task automatic t_ands();
    exec(16'h2CC2);
    exec(16'h2A21);
    exec(16'h2B22);
    idle();
    st(4'hC & 4'h6 & 4'hB, 1'b1, 1'b1);
    peek(7'h22, 4'h0);
    peek(7'h21, 4'h6);
    exec(16'h2E53);
    idle();
    st(4'hE & 4'h5, 1'b0, 1'b1);
    peek(7'h03, 4'hE);
    exec(16'h2F33);
    idle();
    st(4'hE & 4'h3, 1'b0, 1'b1);
    peek(7'h03, 4'h2);
  endtask

  task automatic t_call_clr();
    exec(16'h65A5);
    exec(16'h67FF);
    idle();
    chk(pc, 11'h7FF);
    chk(top, 11'h5A5 + PC_ONE);
    chk(11'(lvl), 11'h002);
    i_carry_load = 1'b1;
    i_carry_value = 1'b1;
    exec(OPC_CLR_CARRY);
    idle();
    st(4'h2, 1'b0, 1'b0);
    chk(pc, exp_pc);
    chk(11'(done), 11'h000);
  endtask

  // Accepted word pulses done, refused word pulses unknown only
  task automatic t_refuse();
    exec(OPC_CLR_CARRY);
    chk(11'(done), 11'h001);
    chk(11'(unk), 11'h000);
    exec(16'h2880);
    chk(11'(done), 11'h000);
    chk(11'(unk), 11'h001);
    st(4'h2, 1'b0, 1'b0);
    chk(pc, exp_pc);
    idle();
    chk(11'({done, unk}), 11'h000);
  endtask

  // Reset in mid-run, then one add on the kept memory
  task automatic t_reset();
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    exp_pc = PC_RST;
    st(ACC_RST, ZERO_RST, CARRY_RST);
    chk(pc, PC_RST);
    chk(top, PC_RST);
    chk(11'(lvl), 11'h000);
    chk(11'(pk), 11'h000);
    chk(11'({done, unk}), 11'h000);
    exec(16'h2C15);
    idle();
    st(4'hA, 1'b0, 1'b0);
    chk(pc, exp_pc);
  endtask

  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    st(ACC_RST, ZERO_RST, CARRY_RST);
    chk(pc, PC_RST);
    preload();
    t_adds();
    t_ands();
    t_call_clr();
    t_refuse();
    t_reset();
    test_done();
  end
endmodule
